/* shared/quad_pos_rev_unit_params.svh */
`ifndef QUAD_POS_REV_UNIT_PARAMS_SVH
`define QUAD_POS_REV_UNIT_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define QUAD_POS_REV_UNIT_OFS_CTRL 5'h00
`define QUAD_POS_REV_UNIT_OFS_POS 5'h04
`define QUAD_POS_REV_UNIT_OFS_REV 5'h08
`define QUAD_POS_REV_UNIT_OFS_PCMP 5'h0C
`define QUAD_POS_REV_UNIT_OFS_PRCMP 5'h10
`define QUAD_POS_REV_UNIT_OFS_PMAX 5'h14
`define QUAD_POS_REV_UNIT_OFS_STAT 5'h18

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define QUAD_POS_REV_UNIT_F_PMODE 0
`define QUAD_POS_REV_UNIT_F_AES 2
`define QUAD_POS_REV_UNIT_F_BES 4
`define QUAD_POS_REV_UNIT_F_SWAP 6
`define QUAD_POS_REV_UNIT_F_IFSEL 7
`define QUAD_POS_REV_UNIT_F_GATE 8
`define QUAD_POS_REV_UNIT_F_ZES 10
`define QUAD_POS_REV_UNIT_F_RMODE 12
`define QUAD_POS_REV_UNIT_CTRL_W 14

// ----------------------------------------------------------------
// status flag positions
// ----------------------------------------------------------------
`define QUAD_POS_REV_UNIT_S_PCMP 0
`define QUAD_POS_REV_UNIT_S_PRCMP 1
`define QUAD_POS_REV_UNIT_S_UDF 2
`define QUAD_POS_REV_UNIT_S_OVF 3
`define QUAD_POS_REV_UNIT_S_ZCLR 4
`define QUAD_POS_REV_UNIT_S_DIRCHG 5
`define QUAD_POS_REV_UNIT_S_BOTH 6
`define QUAD_POS_REV_UNIT_S_ORNG 7
`define QUAD_POS_REV_UNIT_S_DIR 8

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define QUAD_POS_REV_UNIT_RST_CTRL 14'h0000
`define QUAD_POS_REV_UNIT_RST_PMAX 16'hFFFF
`define QUAD_POS_REV_UNIT_RESP_OKAY 2'h0
`define QUAD_POS_REV_UNIT_RESP_SLVERR 2'h2

`endif

/* shared/quad_pos_rev_unit_pkg.sv */
`include "quad_pos_rev_unit_params.svh"

package quad_pos_rev_unit_pkg;

   typedef enum logic [1:0] {
      count_off_mode = 2'h0,
      updown_count_mode = 2'h1,
      phase_diff_mode = 2'h2,
      directed_count_mode = 2'h3
   } quad_pos_rev_unit_pmode_t;

   typedef enum logic [1:0] {
      rev_off_mode = 2'h0,
      rev_index_only_mode = 2'h1,
      rev_wrap_only_mode = 2'h2,
      rev_combined_mode = 2'h3
   } quad_pos_rev_unit_rmode_t;

   // synchroniser bit order: {index, phase b, phase a}
   typedef struct packed {
      logic [2:0] sy1;
      logic [2:0] sy2;
      logic [2:0] prv;
      logic [`QUAD_POS_REV_UNIT_CTRL_W-1:0] ctrl;
      logic [15:0] pos;
      logic [15:0] rev;
      logic [15:0] pcmp;
      logic [15:0] prcmp;
      logic [15:0] pmax;
      logic [7:0] flg;
      logic dir;
      logic aw_got;
      logic w_got;
      logic [4:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } quad_pos_rev_unit_st_t;

endpackage : quad_pos_rev_unit_pkg

/* src/quad_pos_rev_unit_top.sv */
`timescale 1ns/1ps
`include "quad_pos_rev_unit_params.svh"

module quad_pos_rev_unit_top (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic phase_a_in,
   input wire logic phase_b_in,
   input wire logic index_in,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import quad_pos_rev_unit_pkg::*;

   quad_pos_rev_unit_st_t st_r;
   quad_pos_rev_unit_st_t st_nxt;

   logic a_lv, b_lv, z_lv, a_pv, b_pv;
   logic a_ev, b_ev, z_ev, a_up, b_up;
   logic allow, inc, dec, step_up, step_dn, idx_clr, ovf, udf, pos_wr;
   logic rev_up, rev_dn;
   quad_pos_rev_unit_pmode_t pmode;
   quad_pos_rev_unit_rmode_t rmode;
   logic [1:0] aes, bes, zes, gate;
   logic wr_go;
   logic [7:0] set_flg;
   logic [15:0] ctrl_m;

   function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic old);
      edge_hit = (sel[0] & old & ~now) | (sel[1] & ~old & now);
   endfunction : edge_hit

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
      merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      pmode = quad_pos_rev_unit_pmode_t'(st_r.ctrl[`QUAD_POS_REV_UNIT_F_PMODE +: 2]);
      rmode = quad_pos_rev_unit_rmode_t'(st_r.ctrl[`QUAD_POS_REV_UNIT_F_RMODE +: 2]);
      aes = st_r.ctrl[`QUAD_POS_REV_UNIT_F_AES +: 2];
      bes = st_r.ctrl[`QUAD_POS_REV_UNIT_F_BES +: 2];
      zes = st_r.ctrl[`QUAD_POS_REV_UNIT_F_ZES +: 2];
      gate = st_r.ctrl[`QUAD_POS_REV_UNIT_F_GATE +: 2];
      ctrl_m = merge16({2'h0, st_r.ctrl}, st_r.wdata, st_r.wstrb);
      // two-stage sync, then an edge register
      st_nxt.sy1 = {index_in, phase_b_in, phase_a_in};
      st_nxt.sy2 = st_r.sy1;
      st_nxt.prv = st_r.sy2;
      // phase pins exchanged after sync
      a_lv = st_r.ctrl[`QUAD_POS_REV_UNIT_F_SWAP] ? st_r.sy2[1] : st_r.sy2[0];
      b_lv = st_r.ctrl[`QUAD_POS_REV_UNIT_F_SWAP] ? st_r.sy2[0] : st_r.sy2[1];
      a_pv = st_r.ctrl[`QUAD_POS_REV_UNIT_F_SWAP] ? st_r.prv[1] : st_r.prv[0];
      b_pv = st_r.ctrl[`QUAD_POS_REV_UNIT_F_SWAP] ? st_r.prv[0] : st_r.prv[1];
      z_lv = st_r.sy2[2];
      a_ev = edge_hit(aes, a_lv, a_pv);
      b_ev = edge_hit(bes, b_lv, b_pv);
      z_ev = edge_hit(zes, z_lv, st_r.prv[2]);
      // direction votes per phase
      a_up = 1'b0;
      b_up = 1'b0;
      unique case (pmode)
         count_off_mode: begin
            a_ev = 1'b0;
            b_ev = 1'b0;
         end
         updown_count_mode: begin
            a_up = 1'b1;
            b_up = 1'b0;
         end
         phase_diff_mode: begin
            a_up = a_lv ^ b_lv;
            b_up = ~(a_lv ^ b_lv);
         end
         directed_count_mode: begin
            a_ev = 1'b0;
            b_up = a_lv;
         end
      endcase
      // index as gate or clear source
      allow = ~st_r.ctrl[`QUAD_POS_REV_UNIT_F_IFSEL]
              | (gate == 2'h1 & ~z_lv) | (gate == 2'h2 & z_lv);
      inc = allow & ((a_ev & a_up) | (b_ev & b_up));
      dec = allow & ((a_ev & ~a_up) | (b_ev & ~b_up));
      step_up = inc & ~dec;
      step_dn = dec & ~inc;
      idx_clr = z_ev & ~st_r.ctrl[`QUAD_POS_REV_UNIT_F_IFSEL] & (rmode != rev_wrap_only_mode);
      ovf = step_up & (st_r.pos == st_r.pmax);
      udf = step_dn & (st_r.pos == 16'h0000);
      // ------------------------------------------------------------
      // position counter
      // ------------------------------------------------------------
      if (idx_clr) begin
         st_nxt.pos = 16'h0000;
      end else if (ovf && rmode != rev_index_only_mode) begin
         st_nxt.pos = 16'h0000;
      end else if (udf && rmode != rev_index_only_mode) begin
         st_nxt.pos = st_r.pmax;
      end else if (step_up) begin
         st_nxt.pos = st_r.pos + 16'h0001;
      end else if (step_dn) begin
         st_nxt.pos = st_r.pos - 16'h0001;
      end
      if (step_up | step_dn) begin
         st_nxt.dir = step_dn;
      end
      // ------------------------------------------------------------
      // revolution counter
      // ------------------------------------------------------------
      rev_up = 1'b0;
      rev_dn = 1'b0;
      if (rmode != rev_index_only_mode && rmode != rev_off_mode && (ovf | udf)) begin
         rev_up = ovf;
         rev_dn = udf;
      end else if (rmode != rev_wrap_only_mode && rmode != rev_off_mode && idx_clr) begin
         rev_up = ~st_nxt.dir;
         rev_dn = st_nxt.dir;
      end
      if (rev_up) begin
         st_nxt.rev = st_r.rev + 16'h0001;
      end else if (rev_dn) begin
         st_nxt.rev = st_r.rev - 16'h0001;
      end
      // ------------------------------------------------------------
      // event flags
      // ------------------------------------------------------------
      set_flg = 8'h00;
      set_flg[`QUAD_POS_REV_UNIT_S_PCMP] = st_r.pos == st_r.pcmp;
      set_flg[`QUAD_POS_REV_UNIT_S_PRCMP] = (st_r.pos == st_r.prcmp) | (st_r.rev == st_r.prcmp);
      set_flg[`QUAD_POS_REV_UNIT_S_BOTH] = (st_r.pos == st_r.pcmp) & (st_r.rev == st_r.prcmp);
      set_flg[`QUAD_POS_REV_UNIT_S_UDF] = udf;
      set_flg[`QUAD_POS_REV_UNIT_S_OVF] = ovf;
      set_flg[`QUAD_POS_REV_UNIT_S_ZCLR] = idx_clr;
      set_flg[`QUAD_POS_REV_UNIT_S_DIRCHG] = (step_up | step_dn) & (step_dn != st_r.dir);
      set_flg[`QUAD_POS_REV_UNIT_S_ORNG] = (rev_up & st_r.rev == 16'hFFFF)
                              | (rev_dn & st_r.rev == 16'h0000);
      // ------------------------------------------------------------
      // AXI4-Lite write
      // ------------------------------------------------------------
      if (s_axi_awvalid && st_r.awready) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready) begin
         st_nxt.w_got = 1'b1;
         st_nxt.wdata = s_axi_wdata;
         st_nxt.wstrb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      wr_go = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
      pos_wr = wr_go & (st_r.waddr == `QUAD_POS_REV_UNIT_OFS_POS);
      st_nxt.flg = st_r.flg | set_flg;
      if (wr_go) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = `QUAD_POS_REV_UNIT_RESP_OKAY;
         unique case (st_r.waddr)
            `QUAD_POS_REV_UNIT_OFS_CTRL: begin
               st_nxt.ctrl = ctrl_m[`QUAD_POS_REV_UNIT_CTRL_W-1:0];
            end
            `QUAD_POS_REV_UNIT_OFS_POS: st_nxt.pos = merge16(st_r.pos, st_r.wdata, st_r.wstrb);
            `QUAD_POS_REV_UNIT_OFS_REV: st_nxt.rev = merge16(st_r.rev, st_r.wdata, st_r.wstrb);
            `QUAD_POS_REV_UNIT_OFS_PCMP: st_nxt.pcmp = merge16(st_r.pcmp, st_r.wdata, st_r.wstrb);
            `QUAD_POS_REV_UNIT_OFS_PRCMP: st_nxt.prcmp = merge16(st_r.prcmp, st_r.wdata, st_r.wstrb);
            `QUAD_POS_REV_UNIT_OFS_PMAX: st_nxt.pmax = merge16(st_r.pmax, st_r.wdata, st_r.wstrb);
            `QUAD_POS_REV_UNIT_OFS_STAT: begin
               // write one to clear; a new event wins
               st_nxt.flg = (st_r.flg & ~(st_r.wdata[7:0] & {8{st_r.wstrb[0]}})) | set_flg;
            end
            default: st_nxt.bresp = `QUAD_POS_REV_UNIT_RESP_SLVERR;
         endcase
      end
      st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
      st_nxt.wready = ~st_nxt.w_got & ~st_nxt.bvalid;
      // ------------------------------------------------------------
      // AXI4-Lite read
      // ------------------------------------------------------------
      if (s_axi_rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_r.arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = `QUAD_POS_REV_UNIT_RESP_OKAY;
         unique case (s_axi_araddr)
            `QUAD_POS_REV_UNIT_OFS_CTRL: st_nxt.rdata = {18'h00000, st_r.ctrl};
            `QUAD_POS_REV_UNIT_OFS_POS: st_nxt.rdata = {16'h0000, st_r.pos};
            `QUAD_POS_REV_UNIT_OFS_REV: st_nxt.rdata = {16'h0000, st_r.rev};
            `QUAD_POS_REV_UNIT_OFS_PCMP: st_nxt.rdata = {16'h0000, st_r.pcmp};
            `QUAD_POS_REV_UNIT_OFS_PRCMP: st_nxt.rdata = {16'h0000, st_r.prcmp};
            `QUAD_POS_REV_UNIT_OFS_PMAX: st_nxt.rdata = {16'h0000, st_r.pmax};
            `QUAD_POS_REV_UNIT_OFS_STAT: st_nxt.rdata = {23'h000000, st_r.dir, st_r.flg};
            default: begin
               st_nxt.rdata = 32'h00000000;
               st_nxt.rresp = `QUAD_POS_REV_UNIT_RESP_SLVERR;
            end
         endcase
      end
      st_nxt.arready = ~st_nxt.rvalid;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
         st_r.ctrl <= `QUAD_POS_REV_UNIT_RST_CTRL;
         st_r.pmax <= `QUAD_POS_REV_UNIT_RST_PMAX;
         st_r.awready <= 1'b1;
         st_r.wready <= 1'b1;
         st_r.arready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready = st_r.awready;
   assign s_axi_wready = st_r.wready;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rresp = st_r.rresp;
   assign s_axi_rdata = st_r.rdata;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_up_at_max;
      step_up && st_r.pos == st_r.pmax && rmode != rev_index_only_mode && !idx_clr && !pos_wr;
   endsequence

   a_off_hold: assert property ((pmode == count_off_mode && !idx_clr && !pos_wr)
      |=> $stable(st_r.pos)) else $error("position moved while counting is off");
   a_gate_block: assert property ((st_r.ctrl[`QUAD_POS_REV_UNIT_F_IFSEL] && (gate == 2'h0 || gate == 2'h3))
      |-> !step_up && !step_dn) else $error("blocked gate still counted");
   a_gate_low: assert property ((st_r.ctrl[`QUAD_POS_REV_UNIT_F_IFSEL] && gate == 2'h1 && z_lv)
      |-> !step_up && !step_dn) else $error("low gate counted with index high");
   a_one_step: assert property ((step_up && !ovf && !idx_clr && !pos_wr)
      |=> st_r.pos == $past(st_r.pos) + 16'h0001) else $error("up step not one");
   a_ud_dir: assert property ((pmode == updown_count_mode && a_ev && !b_ev && allow)
      |-> step_up) else $error("phase a edge did not count up");
   a_ovf_wrap: assert property (s_up_at_max |=> st_r.pos == 16'h0000 && st_r.flg[`QUAD_POS_REV_UNIT_S_OVF])
      else $error("overflow not wrapped or flagged");
   a_cmp_flag: assert property ((st_r.pos == st_r.pcmp) |=> st_r.flg[`QUAD_POS_REV_UNIT_S_PCMP])
      else $error("compare match not flagged");
   a_idx_clear: assert property ((idx_clr && !pos_wr) |=> st_r.pos == 16'h0000
      && st_r.flg[`QUAD_POS_REV_UNIT_S_ZCLR]) else $error("index edge did not clear");
   a_sync_lag: assert property ((st_r.ctrl[`QUAD_POS_REV_UNIT_F_SWAP] == 1'b0 && $rose(phase_a_in)
      && $stable(st_r.ctrl)) ##2 $stable(st_r.ctrl) |-> st_r.sy2[0] == $past(phase_a_in, 2))
      else $error("phase a sync latency wrong");

   // ----------------------------------------------------------------
   // direction, wrap, gate and event flag checks
   // ----------------------------------------------------------------
   sequence s_dn_at_zero;
      step_dn && st_r.pos == 16'h0000 && rmode != rev_index_only_mode && !idx_clr && !pos_wr;
   endsequence

   a_dn_step: assert property ((step_dn && !udf && !idx_clr && !pos_wr)
      |=> st_r.pos == $past(st_r.pos) - 16'h0001) else $error("down step not one");
   a_udf_reload: assert property (s_dn_at_zero |=> st_r.pos == $past(st_r.pmax)
      && st_r.flg[`QUAD_POS_REV_UNIT_S_UDF]) else $error("underflow not reloaded or flagged");
   a_gate_high: assert property ((st_r.ctrl[`QUAD_POS_REV_UNIT_F_IFSEL] && gate == 2'h2 && !z_lv)
      |-> !step_up && !step_dn) else $error("high gate counted with index low");
   a_ud_down: assert property ((pmode == updown_count_mode && b_ev && !a_ev && allow)
      |-> step_dn) else $error("phase b edge did not count down");
   a_diff_a: assert property ((pmode == phase_diff_mode && a_ev && !b_ev && allow)
      |-> ((a_lv == b_lv) ? step_dn : step_up)) else $error("phase a edge counted wrong way");
   a_diff_b: assert property ((pmode == phase_diff_mode && b_ev && !a_ev && allow)
      |-> ((a_lv == b_lv) ? step_up : step_dn)) else $error("phase b edge counted wrong way");
   a_dir_mode: assert property ((pmode == directed_count_mode && b_ev && allow)
      |-> (a_lv ? step_up : step_dn)) else $error("direction mode counted wrong way");
   a_set_wins: assert property ((set_flg != 8'h00)
      |=> (st_r.flg & $past(set_flg)) == $past(set_flg)) else $error("event flag lost");
   a_rev_range: assert property ((rev_dn && st_r.rev == 16'h0000
      && !(wr_go && st_r.waddr == `QUAD_POS_REV_UNIT_OFS_REV)) |=> st_r.rev == 16'hFFFF
      && st_r.flg[`QUAD_POS_REV_UNIT_S_ORNG]) else $error("revolution wrap not flagged");

endmodule : quad_pos_rev_unit_top

/* bench/quad_pos_rev_unit_enc_model.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// incremental encoder: two phase pins and one index pin
// ------------------------------------------------------------
module quad_pos_rev_unit_enc_model (
   input wire logic clk,
   output logic phase_a,
   output logic phase_b,
   output logic index
);

   initial begin
      phase_a = 1'b0;
      phase_b = 1'b0;
      index = 1'b0;
   end

   // pins move just after an edge, then stand for hold cycles so the synchroniser sees them
   task automatic set_pins(input logic a, input logic b, input logic z, input int hold);
      begin
         @(posedge clk);
         phase_a <= a;
         phase_b <= b;
         index <= z;
         repeat (hold) @(posedge clk);
      end
   endtask : set_pins

endmodule : quad_pos_rev_unit_enc_model

/* bench/quadrature_position_counter_tb_top.sv */
`timescale 1ns/1ps
`include "quad_pos_rev_unit_params.svh"

module quadrature_position_counter_tb_top;
   import quad_pos_rev_unit_pkg::*;
   localparam logic [4:0] CTRL = `QUAD_POS_REV_UNIT_OFS_CTRL;
   localparam logic [4:0] POS = `QUAD_POS_REV_UNIT_OFS_POS;
   localparam logic [4:0] REV = `QUAD_POS_REV_UNIT_OFS_REV;
   localparam logic [4:0] PCMP = `QUAD_POS_REV_UNIT_OFS_PCMP;
   localparam logic [4:0] PRCMP = `QUAD_POS_REV_UNIT_OFS_PRCMP;
   localparam logic [4:0] PMAX = `QUAD_POS_REV_UNIT_OFS_PMAX;
   localparam logic [4:0] STAT = `QUAD_POS_REV_UNIT_OFS_STAT;
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   wire logic phase_a_in;
   wire logic phase_b_in;
   wire logic index_in;
   logic [4:0] s_axi_awaddr = 5'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [4:0] s_axi_araddr = 5'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic [15:0] exp_pos = 16'h0000;
   logic zl = 1'b0;
   int error_cnt = 0;
   int checks = 0;
   int cyc_cnt = 0;

   always #10 clk = ~clk;

   quad_pos_rev_unit_top dut_u (.clk, .arst_n, .phase_a_in, .phase_b_in, .index_in,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   quad_pos_rev_unit_enc_model enc_u (.clk(clk), .phase_a(phase_a_in), .phase_b(phase_b_in),
      .index(index_in));

   // ------------------------------------------------------------
   // reporting and bus access
   // ------------------------------------------------------------
   task automatic wrap_up();
      begin
         $display("checks %0d errors %0d", checks, error_cnt);
         if (error_cnt == 0 && checks > 0) begin
            $display("== PASSED ==");
         end else begin
            $display("== FAILED ==");
         end
         $finish;
      end
   endtask : wrap_up

   task automatic fail(input string m);
      begin
         error_cnt++;
         $display("MISMATCH at %0t: %s", $time, m);
      end
   endtask : fail

   always @(posedge clk) begin
      cyc_cnt++;
      if (cyc_cnt == 20000) begin
         fail("run did not finish in time");
         wrap_up();
      end
   end

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      begin
         @(posedge clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         forever begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
         end
         s_axi_bready <= 1'b0;
         checks++;
         if (s_axi_bresp !== `QUAD_POS_REV_UNIT_RESP_OKAY) fail("write answered with error");
      end
   endtask : wr

   task automatic chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      begin
         @(posedge clk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         forever begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
         end
         d = s_axi_rdata;
         r = s_axi_rresp;
         s_axi_rready <= 1'b0;
         checks++;
         if ((d & m) !== e || r !== ((a == 5'h1C) ? `QUAD_POS_REV_UNIT_RESP_SLVERR : `QUAD_POS_REV_UNIT_RESP_OKAY))
            fail($sformatf("read %h gave %h resp %h", a, d, r));
      end
   endtask : chk

   // ------------------------------------------------------------
   // encoder moves with the expected position step
   // ------------------------------------------------------------
   task automatic mv(input logic a, input logic b, input logic z, input int d);
      begin
         enc_u.set_pins(a, b, z, (cyc_cnt % 2 == 0) ? 4 : 9);
         zl = z;
         exp_pos = exp_pos + 16'(d);
         chk(POS, ALL, {16'h0000, exp_pos});
      end
   endtask : mv

   // one full quadrature cycle from 00; forward has phase A leading
   task automatic cyc(input logic fwd, input int d0, input int d1, input int d2, input int d3);
      begin
         if (fwd) begin
            mv(1'b1, 1'b0, zl, d0);
            mv(1'b1, 1'b1, zl, d1);
            mv(1'b0, 1'b1, zl, d2);
         end else begin
            mv(1'b0, 1'b1, zl, d0);
            mv(1'b1, 1'b1, zl, d1);
            mv(1'b1, 1'b0, zl, d2);
         end
         mv(1'b0, 1'b0, zl, d3);
      end
   endtask : cyc

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      chk(CTRL, ALL, 32'h0);
      chk(PMAX, ALL, 32'h0000_FFFF);
      // compare flags see the equal reset values at once
      chk(STAT, ALL, 32'h43);
      chk(5'h1C, ALL, 32'h0);
      mv(1'b1, 1'b0, 1'b0, 0);
      mv(1'b0, 1'b0, 1'b0, 0);
      wr(CTRL, 32'h19);
      mv(1'b1, 1'b0, 1'b0, 1);
      mv(1'b0, 1'b0, 1'b0, 0);
      mv(1'b0, 1'b1, 1'b0, 0);
      mv(1'b0, 1'b0, 1'b0, -1);
      wr(CTRL, 32'h1D);
      mv(1'b1, 1'b0, 1'b0, 1);
      mv(1'b0, 1'b0, 1'b0, 1);
      wr(CTRL, 32'h15);
      mv(1'b1, 1'b0, 1'b0, 0);
      mv(1'b0, 1'b0, 1'b0, 1);
      wr(CTRL, 32'h11);
      mv(1'b1, 1'b0, 1'b0, 0);
      mv(1'b0, 1'b0, 1'b0, 0);
      wr(CTRL, 32'h59);
      mv(1'b1, 1'b0, 1'b0, 0);
      mv(1'b0, 1'b0, 1'b0, -1);
      mv(1'b0, 1'b1, 1'b0, 1);
      mv(1'b0, 1'b0, 1'b0, 0);
      wr(CTRL, 32'h0A);
      cyc(1'b1, 1, 0, 0, 0);
      cyc(1'b0, 0, -1, 0, 0);
      wr(CTRL, 32'h32);
      cyc(1'b1, 0, 1, 0, 1);
      cyc(1'b0, -1, 0, -1, 0);
      wr(CTRL, 32'h3E);
      cyc(1'b1, 1, 1, 1, 1);
      cyc(1'b0, -1, -1, -1, -1);
      wr(CTRL, 32'h23);
      cyc(1'b1, 0, 1, 0, 0);
      cyc(1'b0, -1, 0, 0, 0);
      for (int g = 0; g < 4; g++) begin
         for (int z = 0; z < 2; z++) begin
            wr(CTRL, 32'h8A | (32'(g) << 8));
            mv(1'b0, 1'b0, z[0], 0);
            cyc(1'b1, ((g == 1 && z == 0) || (g == 2 && z == 1)) ? 1 : 0, 0, 0, 0);
         end
      end
      wr(CTRL, 32'h30A);
      cyc(1'b1, 1, 0, 0, 0);
      mv(1'b0, 1'b0, 1'b0, 0);
      wr(POS, 32'h5);
      exp_pos = 16'h0005;
      wr(PCMP, 32'h6);
      wr(PRCMP, 32'h77);
      wr(CTRL, 32'h3E);
      wr(STAT, 32'hFF);
      chk(STAT, 32'h1, 32'h0);
      mv(1'b1, 1'b0, 1'b0, 1);
      chk(STAT, 32'h1, 32'h1);
      mv(1'b1, 1'b1, 1'b0, 1);
      wr(STAT, 32'hFF);
      mv(1'b1, 1'b0, 1'b0, -1);
      chk(STAT, 32'h120, 32'h120);
      wr(POS, 32'h0);
      exp_pos = 16'h0000;
      wr(STAT, 32'hFF);
      mv(1'b0, 1'b0, 1'b0, -1);
      chk(STAT, 32'h4, 32'h4);
      wr(PMAX, 32'h3);
      wr(POS, 32'h3);
      exp_pos = 16'h0003;
      wr(STAT, 32'hFF);
      // up step at the maximum wraps to zero
      mv(1'b1, 1'b0, 1'b0, -3);
      chk(STAT, 32'h8, 32'h8);
      wr(CTRL, 32'h83E);
      mv(1'b1, 1'b1, 1'b0, 1);
      wr(STAT, 32'hFF);
      mv(1'b1, 1'b1, 1'b1, -1);
      chk(STAT, 32'h10, 32'h10);
      mv(1'b1, 1'b1, 1'b0, 0);
      wr(CTRL, 32'h203E);
      wr(PRCMP, 32'hFFFF);
      wr(STAT, 32'hFF);
      // down step at zero reloads the maximum and wraps the revolution count
      mv(1'b1, 1'b0, 1'b0, 3);
      chk(STAT, 32'h86, 32'h86);
      chk(REV, ALL, 32'h0000_FFFF);
      wr(PCMP, 32'h3);
      chk(STAT, 32'h40, 32'h40);
      wr(STAT, 32'h80);
      chk(STAT, 32'h80, 32'h0);
      wr(CTRL, 32'h1C3E);
      wr(REV, 32'h0);
      wr(STAT, 32'hFF);
      // index-only revolution mode: overflow steps on past the maximum
      mv(1'b1, 1'b1, 1'b0, 1);
      chk(STAT, 32'h8, 32'h8);
      chk(REV, ALL, 32'h0);
      mv(1'b1, 1'b1, 1'b1, -4);
      chk(STAT, 32'h10, 32'h10);
      chk(REV, ALL, 32'h1);
      wr(CTRL, 32'h3C3E);
      mv(1'b1, 1'b1, 1'b0, 0);
      chk(REV, ALL, 32'h2);
      mv(1'b1, 1'b0, 1'b0, 3);
      chk(REV, ALL, 32'h1);
      wrap_up();
   end

endmodule : quadrature_position_counter_tb_top
